// file: hdl/cdmr_pkg.sv
/*
 Constants for the codec digital mix router: register indices, byte addresses,
 field positions, writable masks, reset values and the sidetone gain table.
 Assumes a 32-bit classic Wishbone bus and 24-bit two's complement samples.
*/
package cdmr_pkg;

   // ==========================================================
   // Widths
   localparam int SW = 24;
   localparam int AW = 12;
   localparam int GW = 16;

   // ==========================================================
   // Register indices and byte addresses (index times four)
   localparam int IDX_CTL_ONE = 'h5;
   localparam int IDX_CTL_TWO = 'h6;
   localparam int IDX_AIF_ZERO = 'h7;
   localparam int IDX_RMIX = 'h39;
   localparam int IDX_LMIX = 'h3a;
   localparam int IDX_LOOP = 'h11d;
   localparam logic [AW-1:0] ADDR_CTL_ONE = 12'(4 * IDX_CTL_ONE);
   localparam logic [AW-1:0] ADDR_CTL_TWO = 12'(4 * IDX_CTL_TWO);
   localparam logic [AW-1:0] ADDR_AIF_ZERO = 12'(4 * IDX_AIF_ZERO);
   localparam logic [AW-1:0] ADDR_RMIX = 12'(4 * IDX_RMIX);
   localparam logic [AW-1:0] ADDR_LMIX = 12'(4 * IDX_LMIX);
   localparam logic [AW-1:0] ADDR_LOOP = 12'(4 * IDX_LOOP);

   // ==========================================================
   // Field positions
   localparam int B_RIGHT_NEG = 6;
   localparam int B_LEFT_NEG = 5;
   localparam int B_ADC_EXCH = 8;
   localparam int B_DAC_EXCH = 5;
   localparam int B_SRC_LO = 2;
   localparam int B_LVL_LO = 4;
   localparam int B_LOOP_EN = 1;
   localparam int B_LOOP_MODE = 0;

   // ==========================================================
   // Writable bits and reset values; other bits read as zero
   localparam logic [15:0] MASK_CTL = 16'h0060;
   localparam logic [15:0] MASK_AIF = 16'h0120;
   localparam logic [15:0] MASK_MIX = 16'h00fc;
   localparam logic [15:0] MASK_LOOP = 16'h0003;
   localparam logic [15:0] RST_REG = 16'h0000;

   // ==========================================================
   // Sidetone source codes
   localparam logic [1:0] SRC_LEFT_ADC = 2'h1;
   localparam logic [1:0] SRC_RIGHT_ADC = 2'h2;

   // Q1.15 gain for each 3 dB step; codes 12 to 15 pass unchanged
   function automatic logic [GW-1:0] cdmr_gain(input logic [3:0] level);
      case (level)
         4'h0: return 16'h0207;
         4'h1: return 16'h02de;
         4'h2: return 16'h040c;
         4'h3: return 16'h05b8;
         4'h4: return 16'h0814;
         4'h5: return 16'h0b68;
         4'h6: return 16'h101d;
         4'h7: return 16'h16c3;
         4'h8: return 16'h2027;
         4'h9: return 16'h2d6b;
         4'ha: return 16'h4027;
         4'hb: return 16'h5a9e;
         default: return 16'h8000;
      endcase
   endfunction

endpackage

// file: hdl/cdmr_sat_negate.sv
/*
 Optional negation of one sample with saturation.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module cdmr_sat_negate import cdmr_pkg::*; (
   // Control
   input wire logic neg_i,
   // Data
   input wire logic [SW-1:0] x_i,
   output logic [SW-1:0] y_o
);

   localparam logic [SW-1:0] SMIN = {1'b1, {(SW-1){1'b0}}};
   localparam logic [SW-1:0] SMAX = {1'b0, {(SW-1){1'b1}}};

   // Most negative code has no positive twin, so clamp it
   always_comb begin
      if (!neg_i) begin
         y_o = x_i;
      end else if (x_i == SMIN) begin
         y_o = SMAX;
      end else begin
         y_o = SW'(-x_i);
      end
   end

endmodule // cdmr_sat_negate

// file: hdl/cdmr_sidetone_mix.sv
/*
 One DAC channel's sidetone: source select, 3 dB step attenuation and a
 saturating add onto the receive sample. Combinational; caller registers.
*/
`timescale 1ns/1ps
module cdmr_sidetone_mix import cdmr_pkg::*; (
   // Control
   input wire logic [1:0] source_i,
   input wire logic [3:0] level_i,
   // Data
   input wire logic [SW-1:0] hpf_left_i,
   input wire logic [SW-1:0] hpf_right_i,
   input wire logic [SW-1:0] base_i,
   output logic [SW-1:0] sum_o
);

   logic signed [SW-1:0] pick;
   logic signed [SW+GW:0] prod;
   logic signed [SW:0] wide;

   always_comb begin
      case (source_i)
         SRC_LEFT_ADC: pick = hpf_left_i;
         SRC_RIGHT_ADC: pick = hpf_right_i;
         default: pick = '0;
      endcase
      prod = pick * $signed({1'b0, cdmr_gain(level_i)});
      wide = $signed({base_i[SW-1], base_i}) + $signed({prod[SW+14], prod[SW+14:15]});
      if (wide[SW] != wide[SW-1]) begin
         sum_o = {wide[SW], {(SW-1){~wide[SW]}}};
      end else begin
         sum_o = wide[SW-1:0];
      end
   end

endmodule // cdmr_sidetone_mix

// file: hdl/cdmr_core.sv
/*
 Digital mix router of an audio codec: ADC to transmit routing with negate
 and exchange, receive to DAC routing with negate, exchange and sidetone,
 and a loopback that puts one ADC and the DAC average on transmit.
 Assumes samples arrive as held words qualified by one-cycle valid strobes,
 and that the DAC volume words are already scaled by the DAC volume stage.
*/
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps

// How it works
// - Normal ADC left/right to transmit left/right
// - Invert bits negate right and left ADC
// - ADC exchange bit swaps transmit channels
// - Normal receive left/right feed DAC left/right
// - DAC exchange bit swaps receive channels
// - Invert bits negate right and left DAC
// - Sidetone from HPF output added per DAC
// - Right DAC source: none, left, right, none
// - Left DAC source decodes the same way
// - Level: -36dB to -3dB, then 0dB
// - Loopback enable replaces normal transmit data
// - Mode picks which side carries average
// - Average uses post-volume DAC samples
// - Loopback ADC taken after mono mixing
module cdmr_core import cdmr_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // ADC samples after mono mix, and after high-pass filter
   input wire logic [SW-1:0] adc_left_i,
   input wire logic [SW-1:0] adc_right_i,
   input wire logic [SW-1:0] adc_hpf_left_i,
   input wire logic [SW-1:0] adc_hpf_right_i,
   input wire logic adc_valid_i,
   // DAC samples after digital volume
   input wire logic [SW-1:0] dac_vol_left_i,
   input wire logic [SW-1:0] dac_vol_right_i,
   // Interface receive
   input wire logic [SW-1:0] interface_receive_data_left_i,
   input wire logic [SW-1:0] interface_receive_data_right_i,
   input wire logic interface_receive_valid_i,
   // Interface transmit
   output logic [SW-1:0] interface_transmit_data_left_o,
   output logic [SW-1:0] interface_transmit_data_right_o,
   output logic interface_transmit_valid_o,
   // DAC inputs
   output logic [SW-1:0] dac_left_o,
   output logic [SW-1:0] dac_right_o,
   output logic dac_valid_o
);

   // ==========================================================
   // Register file state
   logic [15:0] adc_dac_control_one_r, adc_dac_control_one_nxt;
   logic [15:0] adc_dac_control_two_r, adc_dac_control_two_nxt;
   logic [15:0] audio_interface_zero_r, audio_interface_zero_nxt;
   logic [15:0] right_dac_sidetone_mix_r, right_dac_sidetone_mix_nxt;
   logic [15:0] left_dac_sidetone_mix_r, left_dac_sidetone_mix_nxt;
   logic [15:0] loopback_control_r, loopback_control_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic [15:0] rd_word;
   logic [15:0] lanes;
   logic wr_take;

   // ==========================================================
   // Decoded controls
   logic right_adc_negate, left_adc_negate;
   logic right_dac_negate, left_dac_negate;
   logic adc_channel_exchange, dac_channel_exchange;
   logic loopback_enable, loopback_mode_select;
   logic [1:0] right_dac_sidetone_source, left_dac_sidetone_source;
   logic [3:0] right_sidetone_level, left_sidetone_level;

   assign right_adc_negate = adc_dac_control_one_r[B_RIGHT_NEG];
   assign left_adc_negate = adc_dac_control_one_r[B_LEFT_NEG];
   assign right_dac_negate = adc_dac_control_two_r[B_RIGHT_NEG];
   assign left_dac_negate = adc_dac_control_two_r[B_LEFT_NEG];
   assign adc_channel_exchange = audio_interface_zero_r[B_ADC_EXCH];
   assign dac_channel_exchange = audio_interface_zero_r[B_DAC_EXCH];
   assign loopback_enable = loopback_control_r[B_LOOP_EN];
   assign loopback_mode_select = loopback_control_r[B_LOOP_MODE];
   assign right_dac_sidetone_source = right_dac_sidetone_mix_r[B_SRC_LO +: 2];
   assign left_dac_sidetone_source = left_dac_sidetone_mix_r[B_SRC_LO +: 2];
   assign right_sidetone_level = right_dac_sidetone_mix_r[B_LVL_LO +: 4];
   assign left_sidetone_level = left_dac_sidetone_mix_r[B_LVL_LO +: 4];

   // ==========================================================
   // Wishbone slave
   // Ack one cycle after the strobe; the write lands on the ack edge,
   // which is exactly when a classic master samples it.
   always_comb begin
      ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
      wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
      lanes = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      case (wb_adr_i)
         ADDR_CTL_ONE: rd_word = adc_dac_control_one_r;
         ADDR_CTL_TWO: rd_word = adc_dac_control_two_r;
         ADDR_AIF_ZERO: rd_word = audio_interface_zero_r;
         ADDR_RMIX: rd_word = right_dac_sidetone_mix_r;
         ADDR_LMIX: rd_word = left_dac_sidetone_mix_r;
         ADDR_LOOP: rd_word = loopback_control_r;
         default: rd_word = 16'h0000;
      endcase
      rdat_nxt = ack_nxt ? {16'h0000, rd_word} : 32'h0000_0000;
      adc_dac_control_one_nxt = adc_dac_control_one_r;
      adc_dac_control_two_nxt = adc_dac_control_two_r;
      audio_interface_zero_nxt = audio_interface_zero_r;
      right_dac_sidetone_mix_nxt = right_dac_sidetone_mix_r;
      left_dac_sidetone_mix_nxt = left_dac_sidetone_mix_r;
      loopback_control_nxt = loopback_control_r;
      if (wr_take) begin
         // Unmapped addresses still ack; the write is dropped
         case (wb_adr_i)
            ADDR_CTL_ONE: adc_dac_control_one_nxt =
               ((adc_dac_control_one_r & ~lanes) | (wb_dat_i[15:0] & lanes)) & MASK_CTL;
            ADDR_CTL_TWO: adc_dac_control_two_nxt =
               ((adc_dac_control_two_r & ~lanes) | (wb_dat_i[15:0] & lanes)) & MASK_CTL;
            ADDR_AIF_ZERO: audio_interface_zero_nxt =
               ((audio_interface_zero_r & ~lanes) | (wb_dat_i[15:0] & lanes)) & MASK_AIF;
            ADDR_RMIX: right_dac_sidetone_mix_nxt =
               ((right_dac_sidetone_mix_r & ~lanes) | (wb_dat_i[15:0] & lanes)) & MASK_MIX;
            ADDR_LMIX: left_dac_sidetone_mix_nxt =
               ((left_dac_sidetone_mix_r & ~lanes) | (wb_dat_i[15:0] & lanes)) & MASK_MIX;
            ADDR_LOOP: loopback_control_nxt =
               ((loopback_control_r & ~lanes) | (wb_dat_i[15:0] & lanes)) & MASK_LOOP;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         adc_dac_control_one_r <= RST_REG;
         adc_dac_control_two_r <= RST_REG;
         audio_interface_zero_r <= RST_REG;
         right_dac_sidetone_mix_r <= RST_REG;
         left_dac_sidetone_mix_r <= RST_REG;
         loopback_control_r <= RST_REG;
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         adc_dac_control_one_r <= adc_dac_control_one_nxt;
         adc_dac_control_two_r <= adc_dac_control_two_nxt;
         audio_interface_zero_r <= audio_interface_zero_nxt;
         right_dac_sidetone_mix_r <= right_dac_sidetone_mix_nxt;
         left_dac_sidetone_mix_r <= left_dac_sidetone_mix_nxt;
         loopback_control_r <= loopback_control_nxt;
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ==========================================================
   // Per-channel negate and sidetone; index 0 is left, 1 is right
   logic [1:0][SW-1:0] adc_in, adc_neg, rx_in, rx_route, dac_neg, dac_mix;
   logic [1:0] adc_neg_en, dac_neg_en;
   logic [1:0][1:0] st_source;
   logic [1:0][3:0] st_level;

   assign adc_in = {adc_right_i, adc_left_i};
   assign rx_in = {interface_receive_data_right_i, interface_receive_data_left_i};
   assign adc_neg_en = {right_adc_negate, left_adc_negate};
   assign dac_neg_en = {right_dac_negate, left_dac_negate};
   // left channel uses second mix register
   assign st_source = {right_dac_sidetone_source, left_dac_sidetone_source};
   assign st_level = {right_sidetone_level, left_sidetone_level};

   assign rx_route[0] = dac_channel_exchange ? rx_in[1] : rx_in[0];
   assign rx_route[1] = dac_channel_exchange ? rx_in[0] : rx_in[1];

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      cdmr_sat_negate u_adc_neg (
         .neg_i(adc_neg_en[ch]),
         .x_i(adc_in[ch]),
         .y_o(adc_neg[ch])
      );
      cdmr_sat_negate u_dac_neg (
         .neg_i(dac_neg_en[ch]),
         .x_i(rx_route[ch]),
         .y_o(dac_neg[ch])
      );
      cdmr_sidetone_mix u_sidetone (
         .source_i(st_source[ch]),
         .level_i(st_level[ch]),
         .hpf_left_i(adc_hpf_left_i),
         .hpf_right_i(adc_hpf_right_i),
         .base_i(dac_neg[ch]),
         .sum_o(dac_mix[ch])
      );
   end

   // ==========================================================
   // Transmit and DAC output registers
   logic [SW-1:0] tx_left_r, tx_left_nxt, tx_right_r, tx_right_nxt;
   logic [SW-1:0] dac_left_r, dac_left_nxt, dac_right_r, dac_right_nxt;
   logic tx_valid_r, tx_valid_nxt, dac_valid_r, dac_valid_nxt;
   logic [SW:0] dac_sum;
   logic [SW-1:0] dac_avg;

   always_comb begin
      // average built from post-volume DAC words
      // sign-extended sum, arithmetic shift by one
      dac_sum = SW'(0) + ($signed({dac_vol_left_i[SW-1], dac_vol_left_i})
               + $signed({dac_vol_right_i[SW-1], dac_vol_right_i}));
      dac_avg = dac_sum[SW:1];
      tx_left_nxt = tx_left_r;
      tx_right_nxt = tx_right_r;
      tx_valid_nxt = adc_valid_i;
      if (adc_valid_i) begin
         if (loopback_enable) begin
            // mode selects which side carries the average
            // ADC word already past mono mixing
            tx_left_nxt = loopback_mode_select ? dac_avg : adc_neg[0];
            tx_right_nxt = loopback_mode_select ? adc_neg[1] : dac_avg;
         end else begin
            tx_left_nxt = adc_channel_exchange ? adc_neg[1] : adc_neg[0];
            tx_right_nxt = adc_channel_exchange ? adc_neg[0] : adc_neg[1];
         end
      end
      dac_left_nxt = interface_receive_valid_i ? dac_mix[0] : dac_left_r;
      dac_right_nxt = interface_receive_valid_i ? dac_mix[1] : dac_right_r;
      dac_valid_nxt = interface_receive_valid_i;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_left_r <= '0;
         tx_right_r <= '0;
         tx_valid_r <= 1'b0;
         dac_left_r <= '0;
         dac_right_r <= '0;
         dac_valid_r <= 1'b0;
      end else begin
         tx_left_r <= tx_left_nxt;
         tx_right_r <= tx_right_nxt;
         tx_valid_r <= tx_valid_nxt;
         dac_left_r <= dac_left_nxt;
         dac_right_r <= dac_right_nxt;
         dac_valid_r <= dac_valid_nxt;
      end
   end

   assign interface_transmit_data_left_o = tx_left_r;
   assign interface_transmit_data_right_o = tx_right_r;
   assign interface_transmit_valid_o = tx_valid_r;
   assign dac_left_o = dac_left_r;
   assign dac_right_o = dac_right_r;
   assign dac_valid_o = dac_valid_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   localparam logic [SW-1:0] SMIN_A = {1'b1, {(SW-1){1'b0}}};
   logic plain_tx, plain_rx;
   logic [SW-1:0] avg_ref;
   // Halves first, then the lost low bits: no wide sum needed
   assign avg_ref = SW'($signed(dac_vol_left_i) >>> 1) + SW'($signed(dac_vol_right_i) >>> 1)
                    + SW'(dac_vol_left_i[0] & dac_vol_right_i[0]);
   assign plain_tx = !loopback_enable && !right_adc_negate && !left_adc_negate;
   assign plain_rx = !right_dac_negate && !left_dac_negate
                     && right_dac_sidetone_source == 2'h0 && left_dac_sidetone_source == 2'h0;

   a_tx_normal_route: assert property (
      adc_valid_i && plain_tx && !adc_channel_exchange |=>
         tx_left_r == $past(adc_left_i) && tx_right_r == $past(adc_right_i) && tx_valid_r)
      else $error("ADC not routed straight to transmit");

   a_adc_left_negate: assert property (
      adc_valid_i && !loopback_enable && !adc_channel_exchange && left_adc_negate
      && adc_left_i != SMIN_A |=> tx_left_r == SW'(-$past(adc_left_i)))
      else $error("Left ADC not negated");

   a_adc_exchange: assert property (
      adc_valid_i && plain_tx && adc_channel_exchange |=>
         tx_left_r == $past(adc_right_i) && tx_right_r == $past(adc_left_i))
      else $error("ADC exchange not applied");

   a_dac_normal_route: assert property (
      interface_receive_valid_i && plain_rx && !dac_channel_exchange |=>
         dac_left_o == $past(interface_receive_data_left_i)
         && dac_right_o == $past(interface_receive_data_right_i) && dac_valid_o)
      else $error("Receive not routed straight to DAC");

   a_dac_exchange: assert property (
      interface_receive_valid_i && plain_rx && dac_channel_exchange |=>
         dac_left_o == $past(interface_receive_data_right_i)
         && dac_right_o == $past(interface_receive_data_left_i))
      else $error("DAC exchange not applied");

   a_dac_right_negate: assert property (
      interface_receive_valid_i && !dac_channel_exchange && right_dac_negate
      && right_dac_sidetone_source == 2'h0 && interface_receive_data_right_i != SMIN_A
      |=> dac_right_o == SW'(-$past(interface_receive_data_right_i)))
      else $error("Right DAC not negated");

   a_sidetone_none_code: assert property (
      interface_receive_valid_i && !dac_channel_exchange && !right_dac_negate
      && right_dac_sidetone_source == 2'h3 |=> dac_right_o == $past(interface_receive_data_right_i))
      else $error("Source code 3 added sidetone");

   a_loop_mode_zero: assert property (
      adc_valid_i && loopback_enable && !loopback_mode_select && !left_adc_negate |=>
         tx_left_r == $past(adc_left_i) && tx_right_r == $past(dac_avg))
      else $error("Loopback mode 0 output wrong");

   a_loop_mode_one: assert property (
      adc_valid_i && loopback_enable && loopback_mode_select && !right_adc_negate |=>
         tx_left_r == $past(dac_avg) && tx_right_r == $past(adc_right_i))
      else $error("Loopback mode 1 output wrong");

   a_loop_average: assert property (
      adc_valid_i && loopback_enable && !loopback_mode_select |=> tx_right_r == $past(avg_ref))
      else $error("Loopback average wrong");

   a_ack_one_cycle: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Ack not a single pulse one cycle after request");

   c_loopback_used: cover property (adc_valid_i && loopback_enable ##1 tx_valid_r);
   c_sidetone_mixed: cover property (interface_receive_valid_i && right_dac_sidetone_source == 2'h1);
   c_reg_write: cover property (wr_take && wb_adr_i == ADDR_LOOP);

endmodule // cdmr_core

// file: tb/cdmr_far_end.sv
/*
 Far-end audio processor model: sends receive samples to the core.
 Assumes the bench calls send right after a rising clock edge.
*/
`timescale 1ns/1ps
module cdmr_far_end import cdmr_pkg::*; (
   // Clock
   input wire logic clk_i,
   // Receive samples toward the core
   output logic [SW-1:0] rx_left_o,
   output logic [SW-1:0] rx_right_o,
   output logic rx_valid_o
);
   initial begin
      rx_left_o = '0;
      rx_right_o = '0;
      rx_valid_o = 1'b0;
   end
   // =======================================================
   // Words inverted after the strobe so stale reads show up
   task automatic send(input logic [SW-1:0] l, input logic [SW-1:0] r);
      rx_left_o <= l;
      rx_right_o <= r;
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_left_o <= ~l;
      rx_right_o <= ~r;
   endtask
endmodule // cdmr_far_end

// file: tb/tb_codec_digital_mix_router.sv
/*
 Self-checking bench for the mix router: register map, both streams.
 Assumes the core answers Wishbone and sample strobes one cycle later.
*/
`timescale 1ns/1ps
module tb_codec_digital_mix_router import cdmr_pkg::*;;
   logic clk_i, arst_n_i, cyc, stb, we, ack, adc_v, rx_v, tx_v, dac_v;
   logic [AW-1:0] adr;
   logic [31:0] wdat, rdat;
   logic [3:0] sel, lane;
   logic [SW-1:0] adc_l, adc_r, hpf_l, hpf_r, vol_l, vol_r, rx_l, rx_r, tx_l, tx_r, dac_l, dac_r;
   logic [15:0] m[6], q;
   logic [47:0] q_tx[$], q_dac[$];
   int err_count, n_checks;
   localparam logic [AW-1:0] ADRS[6] = '{ADDR_CTL_ONE, ADDR_CTL_TWO, ADDR_AIF_ZERO, ADDR_RMIX, ADDR_LMIX, ADDR_LOOP};
   localparam logic [15:0] MSK[6] = '{MASK_CTL, MASK_CTL, MASK_AIF, MASK_MIX, MASK_MIX, MASK_LOOP};

   cdmr_core dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .adc_left_i(adc_l), .adc_right_i(adc_r), .adc_hpf_left_i(hpf_l), .adc_hpf_right_i(hpf_r),
      .adc_valid_i(adc_v), .dac_vol_left_i(vol_l), .dac_vol_right_i(vol_r),
      .interface_receive_data_left_i(rx_l), .interface_receive_data_right_i(rx_r),
      .interface_receive_valid_i(rx_v), .interface_transmit_data_left_o(tx_l),
      .interface_transmit_data_right_o(tx_r), .interface_transmit_valid_o(tx_v),
      .dac_left_o(dac_l), .dac_right_o(dac_r), .dac_valid_o(dac_v));
   cdmr_far_end far (.clk_i(clk_i), .rx_left_o(rx_l), .rx_right_o(rx_r), .rx_valid_o(rx_v));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // =======================================================
   // Reference arithmetic
   function automatic logic [SW-1:0] rv();
      // Full-scale extremes often, to hit saturation
      if ($urandom % 4 == 0) return ($urandom % 2) ? 24'h800000 : 24'h7fffff;
      return SW'($urandom);
   endfunction
   function automatic logic [SW-1:0] ng(input logic n, input logic [SW-1:0] x);
      if (!n) return x;
      return (x == 24'h800000) ? 24'h7fffff : -x;
   endfunction
   function automatic logic [SW-1:0] sa(input logic [SW-1:0] a, input logic [SW-1:0] b);
      logic [SW:0] s;
      s = {a[SW-1], a} + {b[SW-1], b};
      if (s[SW] != s[SW-1]) return s[SW] ? 24'h800000 : 24'h7fffff;
      return s[SW-1:0];
   endfunction
   // Q1.15 gain: -36 dB at code 0, 3 dB steps, 0 dB from code 12
   function automatic int gn(input logic [3:0] c);
      if (c >= 4'hc) return 32768;
      return $rtoi(32768.0 * 10.0 ** ((3.0 * c - 36.0) / 20.0) + 0.5);
   endfunction
   // Sidetone after gain, floored like an arithmetic shift
   function automatic logic [SW-1:0] st(input logic [15:0] r, input logic [SW-1:0] h, input logic [SW-1:0] g);
      logic [SW-1:0] x;
      longint p;
      x = (r[3:2] == 2'h1) ? h : (r[3:2] == 2'h2) ? g : 24'h000000;
      p = $signed(x) * gn(r[7:4]);
      return SW'(p >>> 15);
   endfunction

   // =======================================================
   // Comparison and closing
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected reg at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_stream(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected sample at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (q_tx.size() != 0 || q_dac.size() != 0) err_count++;
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // =======================================================
   // Drivers
   task automatic wb(input logic w, input logic [AW-1:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, sel, adr, wdat} <= {1'b1, 1'b1, w, lane, a, 16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      // A bus that never answers counts as a mismatch
      if (ack !== 1'b1) err_count++;
      q = rdat[15:0];
      {cyc, stb} <= 2'b00;
   endtask
   task automatic adc_tx();
      logic [SW-1:0] a, b, u, v, la, ra, av;
      logic [SW:0] s;
      {a, b, u, v} = {rv(), rv(), rv(), rv()};
      @(posedge clk_i);
      {adc_l, adc_r, vol_l, vol_r, adc_v} <= {a, b, u, v, 1'b1};
      {la, ra, s} = {ng(m[0][5], a), ng(m[0][6], b), {u[SW-1], u} + {v[SW-1], v}};
      av = s[SW:1];
      if (m[5][1]) q_tx.push_back(m[5][0] ? {av, ra} : {la, av});
      else q_tx.push_back(m[2][8] ? {ra, la} : {la, ra});
      @(posedge clk_i);
      adc_v <= 1'b0;
   endtask
   task automatic rx_dac();
      logic [SW-1:0] a, b, h, g, bl, br;
      {a, b, h, g} = {rv(), rv(), rv(), rv()};
      @(posedge clk_i);
      {hpf_l, hpf_r} <= {h, g};
      {bl, br} = m[2][5] ? {b, a} : {a, b};
      q_dac.push_back({sa(ng(m[1][5], bl), st(m[4], h, g)), sa(ng(m[1][6], br), st(m[3], h, g))});
      far.send(a, b);
   endtask

   always @(posedge clk_i) begin
      // A strobe with nothing expected compares against unknown and fails
      if (tx_v === 1'b1) chk_stream({tx_l, tx_r}, q_tx.size() > 0 ? q_tx.pop_front() : 48'hx);
      if (dac_v === 1'b1) chk_stream({dac_l, dac_r}, q_dac.size() > 0 ? q_dac.pop_front() : 48'hx);
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      close_out();
   end

   initial begin
      {cyc, stb, we, adr, wdat, adc_v, adc_l, adc_r, hpf_l, hpf_r, vol_l, vol_r} = '0;
      {err_count, n_checks, arst_n_i} = '0;
      {sel, lane} = {4'h0, 4'h3};
      void'($urandom(32'h4bdbcbd3));
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         wb(1'b0, ADRS[k], 16'h0000);
         chk_reg(q, RST_REG);
         wb(1'b1, ADRS[k], 16'hffff);
         wb(1'b0, ADRS[k], 16'h0000);
         chk_reg(q, MSK[k]);
      end
      wb(1'b1, 12'h000, 16'hffff);
      wb(1'b0, 12'h000, 16'h0000);
      chk_reg(q, 16'h0000);
      // Byte lanes: high lane clears bit 8 only, low lane bit 5
      lane = 4'h2;
      wb(1'b1, ADDR_AIF_ZERO, 16'h0000);
      wb(1'b0, ADDR_AIF_ZERO, 16'h0000);
      chk_reg(q, 16'h0020);
      lane = 4'h1;
      wb(1'b1, ADDR_AIF_ZERO, 16'h0000);
      wb(1'b0, ADDR_AIF_ZERO, 16'h0000);
      chk_reg(q, 16'h0000);
      lane = 4'h3;
      for (int i = 0; i < 60; i++) begin
         for (int k = 0; k < 6; k++) begin
            m[k] = 16'($urandom) & MSK[k];
            wb(1'b1, ADRS[k], m[k]);
         end
         // ADC traffic first; full-scale words test the clamp
         repeat (3) begin
            adc_tx();
            rx_dac();
         end
      end
      repeat (5) @(posedge clk_i);
      close_out();
   end
endmodule // tb_codec_digital_mix_router
